/* logic/hs_pkg.sv */
// homing sequencer shared constants, types and step helpers
// assumes one 10 MHz clock; method codes arrive as plain integers
package hs_pkg;

  // clock and standstill settle time
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_TIME_NS = 500;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // method codes
  localparam logic [7:0] METH_18 = 8'h12;
  localparam logic [7:0] METH_19 = 8'h13;
  localparam logic [7:0] METH_23 = 8'h17;
  localparam logic [7:0] METH_24 = 8'h18;
  localparam logic [7:0] METH_25 = 8'h19;
  localparam logic [7:0] METH_26 = 8'h1A;
  localparam logic [7:0] METH_27 = 8'h1B;
  localparam logic [7:0] METH_28 = 8'h1C;
  localparam logic [7:0] METH_29 = 8'h1D;
  localparam logic [7:0] METH_30 = 8'h1E;
  localparam logic [7:0] METH_31 = 8'h1F;
  localparam logic [7:0] METH_32 = 8'h20;
  localparam logic [7:0] METH_33 = 8'h21;
  localparam logic [7:0] METH_34 = 8'h22;

  // watched inputs, index into the sample vector
  localparam logic [1:0] SIG_POS = 2'h0;
  localparam logic [1:0] SIG_ORG = 2'h1;
  localparam logic [1:0] SIG_IDX = 2'h2;
  localparam int SIG_N = 3;

  // step word layout
  localparam int STEP_W = 5;
  localparam int STEP_REV = 4;
  localparam int STEP_HIGH = 3;
  localparam int STEP_SIG_HI = 2;
  localparam int STEP_SIG_LO = 1;
  localparam int STEP_RISE = 0;
  localparam logic DIR_FWD = 1'b0;
  localparam logic DIR_REV = 1'b1;
  localparam logic SPD_LOW = 1'b0;
  localparam logic SPD_HIGH = 1'b1;
  localparam logic EDGE_FALL = 1'b0;
  localparam logic EDGE_RISE = 1'b1;

  // fallback phase after hitting the negative limit
  localparam logic [1:0] FB_NONE = 2'h0;
  localparam logic [1:0] FB_TURN = 2'h1;
  localparam logic [1:0] FB_FINAL = 2'h2;

  typedef logic [STEP_W-1:0] hs_step_type;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_LOAD   = 6'h02,
    ST_SEARCH = 6'h04,
    ST_STOP   = 6'h08,
    ST_DONE   = 6'h10,
    ST_FAULT  = 6'h20
  } hs_state_type;

  function automatic hs_step_type make_step(input logic rev, input logic high,
                                            input logic [1:0] sig, input logic rise);
    make_step = {rev, high, sig, rise};
  endfunction

  function automatic logic [1:0] step_sig(input hs_step_type s);
    step_sig = s[STEP_SIG_HI:STEP_SIG_LO];
  endfunction

  // approach from the other side: flip direction and edge
  function automatic hs_step_type mirror(input hs_step_type s);
    mirror = make_step(~s[STEP_REV], s[STEP_HIGH], step_sig(s), ~s[STEP_RISE]);
  endfunction

endpackage

/* logic/hs_edge.sv */
// edge detector for the watched limit, origin and index inputs
// assumes inputs already synchronous to clk_i
`timescale 1ns/1ps
module hs_edge #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  // samples and edges
  input  wire logic [W-1:0] sample_i,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] prev;
  logic [W-1:0] next_prev;

  generate
    if (W < 1) begin : g_chk
      $error("hs_edge: W must be at least 1");
    end
  endgenerate

  always_comb begin
    next_prev = sample_i;
    rise_o = sample_i & ~prev;
    fall_o = ~sample_i & prev;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev <= '0;
    end else begin
      prev <= next_prev;
    end
  end

endmodule

/* logic/hs_settle.sv */
// standstill qualifier: standstill must hold CYCLES clocks in a row
// assumes standstill_i is synchronous; clear_i restarts the count
`timescale 1ns/1ps
module hs_settle #(
  parameter int CYCLES = hs_pkg::SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // control and status
  input  wire logic clear_i,
  input  wire logic standstill_i,
  output logic      settled_o
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] TOP = CW'(CYCLES);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  generate
    if (CYCLES < 1) begin : g_chk
      $error("hs_settle: CYCLES must be at least 1");
    end
  endgenerate

  always_comb begin
    next_cnt = cnt;
    if (clear_i || !standstill_i) begin
      next_cnt = '0;
    end else if (cnt != TOP) begin
      next_cnt = cnt + CW'(1);
    end
    settled_o = (cnt == TOP);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule

/* logic/hs_sequencer.sv */
// homing sequencer top: method table, search state machine, outputs
// assumes a speed loop that obeys run/high/reverse and reports standstill
//
// Notes on behaviour
// - method 18: fast forward, slow reverse off limit
// - method 18 limit active: slow reverse only
// - method 19: fast forward, slow reverse off origin
// - method 19 origin active: slow reverse only
// - method 24: three steps, ending forward on rise
// - negative limit in fast reverse: turn forward
// - method 27: fast reverse, slow forward to fall
// - method 27 origin active: slow forward only
// - method 28: three steps, ending reverse on rise
// - method 23: like 19, stop on fall
// - method 25: fast forward fall, slow reverse rise
// - method 26: three steps, ending forward on fall
// - method 29: fast reverse fall, slow forward rise
// - method 30: three steps, ending reverse on fall
// - methods 31 and 32 are reserved
// - method 33: reverse to first index pulse
// - method 34: forward to first index pulse
`timescale 1ns/1ps
module hs_sequencer #(
  parameter int SETTLE_CYCLES = hs_pkg::SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // command
  input  wire logic       start_i,
  input  wire logic [7:0] method_i,
  // axis sensors
  input  wire logic       pos_limit_i,
  input  wire logic       neg_limit_i,
  input  wire logic       origin_i,
  input  wire logic       index_i,
  input  wire logic       standstill_i,
  // speed loop command
  output logic            run_o,
  output logic            high_speed_o,
  output logic            reverse_o,
  // status
  output logic            busy_o,
  output logic            done_o,
  output logic            error_o
);

  hs_pkg::hs_state_type state;
  hs_pkg::hs_state_type next_state;
  logic [7:0]           method_q;
  logic [7:0]           next_method_q;
  logic [1:0]           idx;
  logic [1:0]           next_idx;
  logic [1:0]           fb;
  logic [1:0]           next_fb;
  logic                 next_run;
  logic                 next_high;
  logic                 next_rev;
  logic                 next_busy;
  logic                 next_done;
  logic                 next_err;

  // method table
  hs_pkg::hs_step_type  tbl0;
  hs_pkg::hs_step_type  tbl1;
  hs_pkg::hs_step_type  tbl2;
  logic [1:0]           last;
  logic                 skip;
  logic                 tbl_valid;

  hs_pkg::hs_step_type  cur;
  hs_pkg::hs_step_type  nxt;
  logic [hs_pkg::SIG_N-1:0] lvl;
  logic [hs_pkg::SIG_N-1:0] rise_v;
  logic [hs_pkg::SIG_N-1:0] fall_v;
  logic                 hit;
  logic                 final_step;
  logic                 turn;
  logic                 settled;

  assign lvl = {index_i, origin_i, pos_limit_i};

  hs_edge #(
    .W (hs_pkg::SIG_N)
  ) u_edge (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .sample_i  (lvl),
    .rise_o    (rise_v),
    .fall_o    (fall_v)
  );

  hs_settle #(
    .CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .clear_i      (state != hs_pkg::ST_STOP),
    .standstill_i (standstill_i),
    .settled_o    (settled)
  );

  // step in force for a given position in the program
  function automatic hs_pkg::hs_step_type pick(input logic [1:0] i, input logic [1:0] f,
                                               input hs_pkg::hs_step_type t0,
                                               input hs_pkg::hs_step_type t1,
                                               input hs_pkg::hs_step_type t2);
    pick = t0;
    if (f == hs_pkg::FB_TURN) begin
      pick = hs_pkg::make_step(hs_pkg::DIR_FWD, hs_pkg::SPD_HIGH, hs_pkg::step_sig(t0),
                               ~t0[hs_pkg::STEP_RISE]);
    end else if (f == hs_pkg::FB_FINAL) begin
      pick = hs_pkg::mirror(t1);
    end else if (i == 2'h1) begin
      pick = t1;
    end else if (i == 2'h2) begin
      pick = t2;
    end
  endfunction

  always_comb begin
    tbl0 = '0;
    tbl1 = '0;
    tbl2 = '0;
    last = 2'h1;
    skip = 1'b1;
    tbl_valid = 1'b1;
    case (method_q)
      hs_pkg::METH_18: begin
        tbl0 = hs_pkg::make_step(hs_pkg::DIR_FWD, 1'b1, hs_pkg::SIG_POS, 1'b1);
        tbl1 = hs_pkg::make_step(hs_pkg::DIR_REV, 1'b0, hs_pkg::SIG_POS, 1'b0);
      end
      hs_pkg::METH_19, hs_pkg::METH_23: begin
        tbl0 = hs_pkg::make_step(hs_pkg::DIR_FWD, 1'b1, hs_pkg::SIG_ORG, 1'b1);
        tbl1 = hs_pkg::make_step(hs_pkg::DIR_REV, 1'b0, hs_pkg::SIG_ORG, 1'b0);
      end
      hs_pkg::METH_24: begin
        tbl0 = hs_pkg::make_step(hs_pkg::DIR_FWD, 1'b1, hs_pkg::SIG_ORG, 1'b1);
        tbl1 = hs_pkg::make_step(hs_pkg::DIR_REV, 1'b0, hs_pkg::SIG_ORG, 1'b0);
        tbl2 = hs_pkg::make_step(hs_pkg::DIR_FWD, 1'b0, hs_pkg::SIG_ORG, 1'b1);
        last = 2'h2;
      end
      hs_pkg::METH_25: begin
        tbl0 = hs_pkg::make_step(hs_pkg::DIR_FWD, 1'b1, hs_pkg::SIG_ORG, 1'b0);
        tbl1 = hs_pkg::make_step(hs_pkg::DIR_REV, 1'b0, hs_pkg::SIG_ORG, 1'b1);
        skip = 1'b0;
      end
      hs_pkg::METH_26: begin
        tbl0 = hs_pkg::make_step(hs_pkg::DIR_FWD, 1'b1, hs_pkg::SIG_ORG, 1'b0);
        tbl1 = hs_pkg::make_step(hs_pkg::DIR_REV, 1'b0, hs_pkg::SIG_ORG, 1'b1);
        tbl2 = hs_pkg::make_step(hs_pkg::DIR_FWD, 1'b0, hs_pkg::SIG_ORG, 1'b0);
        last = 2'h2;
        skip = 1'b0;
      end
      hs_pkg::METH_27: begin
        tbl0 = hs_pkg::make_step(hs_pkg::DIR_REV, 1'b1, hs_pkg::SIG_ORG, 1'b1);
        tbl1 = hs_pkg::make_step(hs_pkg::DIR_FWD, 1'b0, hs_pkg::SIG_ORG, 1'b0);
      end
      hs_pkg::METH_28: begin
        tbl0 = hs_pkg::make_step(hs_pkg::DIR_REV, 1'b1, hs_pkg::SIG_ORG, 1'b1);
        tbl1 = hs_pkg::make_step(hs_pkg::DIR_FWD, 1'b0, hs_pkg::SIG_ORG, 1'b0);
        tbl2 = hs_pkg::make_step(hs_pkg::DIR_REV, 1'b0, hs_pkg::SIG_ORG, 1'b1);
        last = 2'h2;
      end
      hs_pkg::METH_29: begin
        tbl0 = hs_pkg::make_step(hs_pkg::DIR_REV, 1'b1, hs_pkg::SIG_ORG, 1'b0);
        tbl1 = hs_pkg::make_step(hs_pkg::DIR_FWD, 1'b0, hs_pkg::SIG_ORG, 1'b1);
        skip = 1'b0;
      end
      hs_pkg::METH_30: begin
        tbl0 = hs_pkg::make_step(hs_pkg::DIR_REV, 1'b1, hs_pkg::SIG_ORG, 1'b0);
        tbl1 = hs_pkg::make_step(hs_pkg::DIR_FWD, 1'b0, hs_pkg::SIG_ORG, 1'b1);
        tbl2 = hs_pkg::make_step(hs_pkg::DIR_REV, 1'b0, hs_pkg::SIG_ORG, 1'b0);
        last = 2'h2;
        skip = 1'b0;
      end
      hs_pkg::METH_33: begin
        tbl0 = hs_pkg::make_step(hs_pkg::DIR_REV, 1'b0, hs_pkg::SIG_IDX, 1'b1);
        last = 2'h0;
        skip = 1'b0;
      end
      hs_pkg::METH_34: begin
        tbl0 = hs_pkg::make_step(hs_pkg::DIR_FWD, 1'b0, hs_pkg::SIG_IDX, 1'b1);
        last = 2'h0;
        skip = 1'b0;
      end
      default: begin
        // reserved 31, 32 and everything unsupported
        tbl_valid = 1'b0;
        skip = 1'b0;
      end
    endcase
  end

  always_comb begin
    cur = pick(idx, fb, tbl0, tbl1, tbl2);
    hit = cur[hs_pkg::STEP_RISE] ? rise_v[hs_pkg::step_sig(cur)]
                                 : fall_v[hs_pkg::step_sig(cur)];
    final_step = (fb == hs_pkg::FB_FINAL) || (fb == hs_pkg::FB_NONE && idx == last);
    turn = (fb == hs_pkg::FB_NONE) && (idx == 2'h0) && cur[hs_pkg::STEP_REV]
           && cur[hs_pkg::STEP_HIGH] && (hs_pkg::step_sig(cur) == hs_pkg::SIG_ORG)
           && neg_limit_i;
  end

  always_comb begin
    next_state = state;
    next_method_q = method_q;
    next_idx = idx;
    next_fb = fb;
    case (state)
      hs_pkg::ST_IDLE, hs_pkg::ST_DONE, hs_pkg::ST_FAULT: begin
        if (start_i) begin
          next_method_q = method_i;
          next_idx = 2'h0;
          next_fb = hs_pkg::FB_NONE;
          next_state = hs_pkg::ST_LOAD;
        end
      end
      hs_pkg::ST_LOAD: begin
        if (!tbl_valid) begin
          next_state = hs_pkg::ST_FAULT;
        end else begin
          // already on the target: skip the fast phase
          if (skip && lvl[hs_pkg::step_sig(tbl0)]) begin
            next_idx = 2'h1;
          end
          next_state = hs_pkg::ST_SEARCH;
        end
      end
      hs_pkg::ST_SEARCH: begin
        if (hit && final_step) begin
          next_state = hs_pkg::ST_DONE;
        end else if (hit) begin
          next_state = hs_pkg::ST_STOP;
          if (fb == hs_pkg::FB_TURN) begin
            next_fb = hs_pkg::FB_FINAL;
          end else begin
            next_idx = idx + 2'h1;
          end
        end else if (turn) begin
          next_state = hs_pkg::ST_STOP;
          next_fb = hs_pkg::FB_TURN;
        end
      end
      hs_pkg::ST_STOP: begin
        if (settled) begin
          next_state = hs_pkg::ST_SEARCH;
        end
      end
      default: begin
        next_state = hs_pkg::ST_IDLE;
      end
    endcase
  end

  always_comb begin
    nxt = pick(next_idx, next_fb, tbl0, tbl1, tbl2);
    next_run = (next_state == hs_pkg::ST_SEARCH);
    next_high = next_run && nxt[hs_pkg::STEP_HIGH];
    next_rev = next_run ? nxt[hs_pkg::STEP_REV] : reverse_o;
    next_busy = (next_state == hs_pkg::ST_LOAD) || (next_state == hs_pkg::ST_SEARCH)
                || (next_state == hs_pkg::ST_STOP);
    next_done = (next_state == hs_pkg::ST_DONE);
    next_err = (next_state == hs_pkg::ST_FAULT);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= hs_pkg::ST_IDLE;
      method_q <= 8'h00;
      idx <= 2'h0;
      fb <= 2'h0;
      run_o <= 1'b0;
      high_speed_o <= 1'b0;
      reverse_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      error_o <= 1'b0;
    end else begin
      state <= next_state;
      method_q <= next_method_q;
      idx <= next_idx;
      fb <= next_fb;
      run_o <= next_run;
      high_speed_o <= next_high;
      reverse_o <= next_rev;
      busy_o <= next_busy;
      done_o <= next_done;
      error_o <= next_err;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_stop_zero;
    (state == hs_pkg::ST_STOP) |-> !run_o && busy_o;
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("moving during stop");

  property p_resume_settled;
    $rose(run_o) && $past(state == hs_pkg::ST_STOP) |-> $past(settled) && $past(standstill_i);
  endproperty
  a_resume_settled: assert property (p_resume_settled) else $error("resumed early");

  property p_done_hold;
    (state == hs_pkg::ST_DONE) |-> done_o && !run_o && !high_speed_o && !busy_o;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done not held at zero");

  property p_bad_method;
    (state == hs_pkg::ST_LOAD) && !tbl_valid |=> error_o && !run_o && !done_o;
  endproperty
  a_bad_method: assert property (p_bad_method) else $error("bad method not refused");

  property p_m18_fast;
    (state == hs_pkg::ST_LOAD) && (method_q == hs_pkg::METH_18) && !pos_limit_i
      |=> run_o && high_speed_o && !reverse_o;
  endproperty
  a_m18_fast: assert property (p_m18_fast) else $error("method 18 start wrong");

  property p_m18_skip;
    (state == hs_pkg::ST_LOAD) && (method_q == hs_pkg::METH_18) && pos_limit_i
      |=> run_o && !high_speed_o && reverse_o;
  endproperty
  a_m18_skip: assert property (p_m18_skip) else $error("method 18 skip wrong");

  property p_org_skip;
    (state == hs_pkg::ST_LOAD) && tbl_valid && skip && origin_i
      && (hs_pkg::step_sig(tbl0) == hs_pkg::SIG_ORG) |=> (idx == 2'h1) && !high_speed_o;
  endproperty
  a_org_skip: assert property (p_org_skip) else $error("origin skip wrong");

  property p_final;
    (state == hs_pkg::ST_SEARCH) && hit && final_step |=> done_o && !run_o ##1 done_o;
  endproperty
  a_final: assert property (p_final) else $error("final edge did not stop");

  property p_turn;
    (state == hs_pkg::ST_SEARCH) && turn && !hit |=> (fb == hs_pkg::FB_TURN) && !run_o;
  endproperty
  a_turn: assert property (p_turn) else $error("no turn at negative limit");

  property p_index;
    run_o && ((method_q == hs_pkg::METH_33) || (method_q == hs_pkg::METH_34))
      |-> !high_speed_o && (reverse_o == (method_q == hs_pkg::METH_33));
  endproperty
  a_index: assert property (p_index) else $error("index search motion wrong");

  c_done_24: cover property ((method_q == hs_pkg::METH_24) && $rose(done_o));
  c_fault: cover property ($rose(error_o));
  c_turn: cover property ((fb == hs_pkg::FB_FINAL) && $rose(done_o));
  c_index: cover property ((method_q == hs_pkg::METH_34) && $rose(done_o));

endmodule

/* tb/hs_axis_model.sv */
// behavioural axis: speed loop, limit switches, origin switch, encoder index
// assumes commands change on rising edges; sensors move on falling edges
`timescale 1ns/1ps
module hs_axis_model #(
  parameter int ORG_LO = 100,
  parameter int ORG_HI = 140,
  parameter int PLIM   = 400,
  parameter int NLIM   = -400,
  parameter int IDX    = 64
) (
  // clock
  input  wire logic               clk_i,
  // bench control
  input  wire logic               load_i,
  input  wire logic signed [15:0] load_pos_i,
  input  wire logic        [2:0]  decel_i,
  // speed command
  input  wire logic               run_i,
  input  wire logic               high_i,
  input  wire logic               reverse_i,
  // sensors
  output logic                    pos_limit_o,
  output logic                    neg_limit_o,
  output logic                    origin_o,
  output logic                    index_o,
  output logic                    standstill_o,
  output int                      pos_o
);
  int stop_cnt;
  int step;

  initial begin
    pos_o = 0;
    stop_cnt = 7;
  end

  always @(negedge clk_i) begin
    step = high_i ? 4 : 1;
    if (load_i) begin
      pos_o <= int'(load_pos_i);
      stop_cnt <= 7;
    end else if (run_i) begin
      pos_o <= reverse_i ? pos_o - step : pos_o + step;
      stop_cnt <= 0;
    end else if (stop_cnt < 7) begin
      stop_cnt <= stop_cnt + 1;
    end
  end

  // zero speed reported only after the decel time has run out
  assign standstill_o = !run_i && (stop_cnt >= int'(decel_i));
  assign origin_o     = (pos_o >= ORG_LO) && (pos_o < ORG_HI);
  assign pos_limit_o  = pos_o >= PLIM;
  assign neg_limit_o  = pos_o <= NLIM;
  assign index_o      = (pos_o & (IDX - 1)) < 2;
endmodule

/* tb/homing_sequencer_bench.sv */
// self-checking bench for the homing sequencer against the axis model
// assumes settle count shortened to 2; geometry shared with the model
`timescale 1ns/1ps
module homing_sequencer_bench;
  localparam int SET = 2;
  logic clk_i, reset_n_i, start_i, run_o, high_speed_o, reverse_o, busy_o, done_o, error_o;
  logic [7:0] method_i;
  logic pos_limit_i, neg_limit_i, origin_i, index_i, standstill_i, load;
  logic signed [15:0] load_pos;
  logic [2:0] decel;
  int pos, n_fail, tests_run, st_cnt;
  logic have_dir, last_dir, used_high, moved, prev_run;
  int valid_m[14] = '{18, 19, 23, 24, 25, 26, 27, 28, 29, 30, 33, 34, 18, 19};

  hs_sequencer #(.SETTLE_CYCLES(SET)) hs_sequencer_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start_i), .method_i(method_i),
    .pos_limit_i(pos_limit_i), .neg_limit_i(neg_limit_i), .origin_i(origin_i),
    .index_i(index_i), .standstill_i(standstill_i), .run_o(run_o),
    .high_speed_o(high_speed_o), .reverse_o(reverse_o), .busy_o(busy_o),
    .done_o(done_o), .error_o(error_o));

  hs_axis_model hs_axis_model_inst (
    .clk_i(clk_i), .load_i(load), .load_pos_i(load_pos), .decel_i(decel),
    .run_i(run_o), .high_i(high_speed_o), .reverse_i(reverse_o),
    .pos_limit_o(pos_limit_i), .neg_limit_o(neg_limit_i), .origin_o(origin_i),
    .index_o(index_i), .standstill_o(standstill_i), .pos_o(pos));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic check_bit(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  task automatic check_pos(input int got, input int exp, input int tol, input string msg);
    tests_run++;
    if (got > exp + tol || got < exp - tol) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s pos %0d exp %0d", $time, msg, got, exp);
    end
  endtask

  function automatic bit is_valid(input int m);
    return (m == 18 || m == 19 || (m >= 23 && m <= 30) || m == 33 || m == 34);
  endfunction

  function automatic int exp_pos(input int m, input int s);
    bit act = (s >= 100 && s < 140);
    case (m)
      18: return 399;
      19, 23, 30: return 99;
      24: return 100;
      25, 28: return 139;
      26: return 140;
      27: return (!act && s < 100) ? 139 : 140;
      29: return (s < 100) ? 99 : 100;
      33: return ((s - 2) / 64) * 64 + 1;
      default: return ((s + 63) / 64) * 64;
    endcase
  endfunction

  function automatic bit exp_high(input int m, input int s);
    bit act = (s >= 100 && s < 140);
    case (m)
      18: return s < 400;
      19, 23, 24, 27, 28: return !act;
      33, 34: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction

  // start positions per method: off target, on target (off the index for 33 and 34), second off-target start (far side only for 27 to 30)
  function automatic int start_of(input int m, input int k);
    int st[3];
    if (m >= 33)
      st = '{300, 120, 200};
    else if (m >= 27)
      st = '{0, 120, 300};
    else if (m == 18)
      st = '{0, 450, 120};
    else
      st = '{0, 120, 50};
    return st[k];
  endfunction

  // phase monitor: settle before reversal, zero speed means low speed
  always @(negedge clk_i) begin
    if (run_o === 1'b1 && prev_run === 1'b0 && have_dir && reverse_o !== last_dir)
      check_bit(st_cnt >= SET, 1'b1, "reversal without standstill");
    if (run_o === 1'b1) begin
      last_dir = reverse_o;
      have_dir = 1'b1;
      used_high = used_high | high_speed_o;
      moved = 1'b1;
      st_cnt = 0;
    end else if (standstill_i) begin
      st_cnt++;
    end else begin
      st_cnt = 0;
    end
    if (run_o === 1'b0 && high_speed_o !== 1'b0)
      check_bit(high_speed_o, 1'b0, "high speed while stopped");
    prev_run = run_o;
  end

  task automatic run_one(input int m, input int s);
    int n;
    int p;
    @(negedge clk_i);
    // non-blocking so the model sees load on exactly one falling edge
    load <= 1'b1;
    load_pos = s[15:0];
    decel = 3'($urandom_range(6, 1));
    @(negedge clk_i);
    load <= 1'b0;
    have_dir = 1'b0;
    used_high = 1'b0;
    moved = 1'b0;
    method_i = m[7:0];
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    check_bit(busy_o, 1'b1, "busy after start");
    check_bit(done_o | error_o, 1'b0, "flags not cleared by start");
    @(negedge clk_i);
    n = 0;
    while (done_o !== 1'b1 && error_o !== 1'b1 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    check_bit(n < 5000, 1'b1, "run did not finish");
    check_bit(busy_o, 1'b0, "busy after finish");
    if (is_valid(m)) begin
      check_bit(done_o, 1'b1, "done flag");
      check_bit(error_o, 1'b0, "error on valid code");
      check_pos(pos, exp_pos(m, s), 4, "final stop");
      check_bit(used_high, exp_high(m, s), "high phase use");
      p = pos;
      repeat (10) @(negedge clk_i);
      check_pos(pos, p, 0, "hold after done");
      check_bit(done_o, 1'b1, "done held");
    end else begin
      check_bit(error_o, 1'b1, "error flag");
      check_bit(moved, 1'b0, "motion on bad code");
    end
    $display("test method %0d start %0d ended", m, s);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #9_000_000;
    n_fail++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    conclude();
  end

  initial begin
    int m;
    int s;
    int bad[6] = '{31, 32, 0, 17, 35, 255};
    n_fail = 0;
    tests_run = 0;
    st_cnt = 0;
    prev_run = 1'b0;
    have_dir = 1'b0;
    reset_n_i = 1'b0;
    start_i = 1'b0;
    method_i = 8'h00;
    load = 1'b0;
    load_pos = 16'h0000;
    decel = 3'h1;
    void'($urandom(32'hCD88));
    repeat (10) @(negedge clk_i);
    reset_n_i = 1'b1;
    check_bit(busy_o | done_o | error_o | run_o, 1'b0, "outputs after reset");
    // corner cases: active and inactive start for each method, inactive only for 33 and 34
    for (int i = 0; i < 12; i++) begin
      m = valid_m[i];
      for (int k = 0; k < 3; k++) run_one(m, start_of(m, k));
    end
    for (int i = 0; i < 6; i++) run_one(bad[i], 120);
    // random mix with random decel times
    for (int i = 0; i < 16; i++) begin
      m = ($urandom_range(7, 0) == 0) ? int'($urandom_range(255, 0)) : valid_m[$urandom_range(13, 0)];
      s = start_of(m, int'($urandom_range(2, 0)));
      run_one(m, s);
    end
    conclude();
  end
endmodule
